/* core/dbm_pkg.sv */
// Constants, register map and state encoding of the two-channel disk bus-master engine
package dbm_pkg;

   // Channel count and register window size
   localparam int DBM_CHANNELS = 2;
   localparam int DBM_WINDOW_BYTES = 16;

   // Register offsets, index 0 primary and index 1 secondary
   localparam logic [1:0][3:0] DBM_OFS_CMD = {4'h8, 4'h0};
   localparam logic [1:0][3:0] DBM_OFS_STS = {4'hA, 4'h2};
   localparam logic [1:0][3:0] DBM_OFS_PTR = {4'hC, 4'h4};

   // Command register fields
   localparam int DBM_CMD_START_BIT = 0;
   localparam int DBM_CMD_DIR_BIT = 3;
   localparam logic [7:0] DBM_CMD_RW_MASK = 8'h09;
   localparam logic [7:0] DBM_CMD_RESET = 8'h00;

   // Status register fields
   localparam int DBM_STS_ACT_BIT = 0;
   localparam int DBM_STS_ERR_BIT = 1;
   localparam int DBM_STS_IRQ_BIT = 2;
   localparam int DBM_STS_DRV0_BIT = 5;
   localparam int DBM_STS_DRV1_BIT = 6;
   localparam logic DBM_SIMPLEX = 1'b0;
   localparam logic [1:0] DBM_DRV_CAP_RESET = 2'h0;

   // Table pointer register
   localparam logic [31:0] DBM_PTR_MASK = 32'hFFFFFFFC;
   localparam logic [31:0] DBM_PTR_RESET = 32'h00000000;

   // Descriptor layout and stepping
   localparam logic [15:0] DBM_DESC_STEP = 16'h0008;
   localparam logic [15:0] DBM_DESC_CNT_OFS = 16'h0004;
   localparam int DBM_DESC_EOT_BIT = 31;
   localparam logic [16:0] DBM_FULL_REGION = 17'h10000;
   localparam logic [16:0] DBM_WORD_BYTES = 17'h00004;
   localparam logic [14:0] DBM_ADDR_LO_STEP = 15'h0002;

   // Drive timing mode after reset: multiword DMA mode 0
   localparam logic [1:0] DBM_MDMA_MODE_RESET = 2'h0;

   // Channel sequencer states
   typedef enum logic [2:0] {
      DBM_IDLE = 3'b000,
      DBM_FETCH_ADDR = 3'b001,
      DBM_FETCH_CNT = 3'b010,
      DBM_MOVE = 3'b011,
      DBM_HALT = 3'b100
   } dbm_state_t;

endpackage : dbm_pkg

/* core/dbm_mem_if.sv */
// Memory request bundle between a channel sequencer and the memory arbiter
`timescale 1ns/1ps
`default_nettype none

interface dbm_mem_if;
   logic req;
   logic we;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic ack;
   logic err;

   // Channel side issues requests
   modport master (output req, output we, output addr, output wdata, input rdata, input ack, input err);
   // Arbiter side answers them
   modport slave (input req, input we, input addr, input wdata, output rdata, output ack, output err);
endinterface : dbm_mem_if

`default_nettype wire

/* core/dbm_arb.sv */
// Two-way memory arbiter that holds a grant until the outstanding access is answered
`timescale 1ns/1ps
`default_nettype none

module dbm_arb (
   input wire logic clock,
   input wire logic rst_n,
   dbm_mem_if.slave ch0,
   dbm_mem_if.slave ch1,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic mem_err
);

   logic lock_r;
   logic owner_r;
   logic gnt;

   // Locked owner keeps the bus, otherwise primary wins
   always_comb begin
      gnt = lock_r ? owner_r : !ch0.req;
   end

   // Route the granted channel to memory
   assign mem_req = gnt ? ch1.req : ch0.req;
   assign mem_we = gnt ? ch1.we : ch0.we;
   assign mem_addr = gnt ? ch1.addr : ch0.addr;
   assign mem_wdata = gnt ? ch1.wdata : ch0.wdata;

   // Acknowledge and error go only to the granted channel; read data goes to both
   assign ch0.rdata = mem_rdata;
   assign ch1.rdata = mem_rdata;
   assign ch0.ack = mem_ack && !gnt;
   assign ch1.ack = mem_ack && gnt;
   assign ch0.err = mem_err && mem_ack && !gnt;
   assign ch1.err = mem_err && mem_ack && gnt;

   // Grant lock while an access waits for its answer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lock_r <= 1'b0;
         owner_r <= 1'b0;
      end else if (mem_req && !mem_ack) begin
         lock_r <= 1'b1;
         owner_r <= gnt;
      end else begin
         lock_r <= 1'b0;
      end
   end

endmodule : dbm_arb

`default_nettype wire

/* core/dbm_top.sv */
// Two-channel scatter/gather disk bus-master engine with its 16-byte IO register window
// Notes on behaviour
// - Two independent channels, each with own registers.
// - Drive timing starts at multiword DMA mode zero.
// - Descriptor: address dword, count halfword, end flag.
// - Count field zero means full 64K region.
// - End flag stops engine after that region.
// - Address counter steps only bits 15 to 1.
// - Register window spans sixteen bytes of IO.
// - Registers take byte, word and dword accesses.
// - Command, status, pointer at fixed per-channel offsets.
// - Command resets zero, reserved bits read zero.
// - Direction bit: zero reads memory, one writes.
// - Only a zero-to-one start edge begins transfer.
// - Data moves only while start bit set.
// - Clearing start halts and discards all state.
// - Abort may drop data held from drive.
// - Active sets on start, clears at end or stop.
// - Interrupt flag sets on drive edge, write-one clears.
// - Drive edge flushes data; status read waits.
// - Error flag sets on memory error, write-one clears.
`timescale 1ns/1ps
`default_nettype none

module dbm_top
   import dbm_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] io_addr,
   input wire logic [3:0] io_be,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [31:0] io_wdata,
   output logic [31:0] io_rdata,
   output logic io_ack,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic mem_err,
   output logic [1:0][31:0] drv_tx_data,
   output logic [1:0] drv_tx_valid,
   input wire logic [1:0] drv_tx_ready,
   input wire logic [1:0][31:0] drv_rx_data,
   input wire logic [1:0] drv_rx_valid,
   output logic [1:0] drv_rx_ready,
   input wire logic [1:0] drive_interrupt_line,
   output logic [1:0][1:0] drive_timing_mode
);

   logic io_ack_r;
   logic [31:0] io_rdata_r;
   logic io_stall;
   logic io_take;
   logic [31:0] rd_word;
   logic [1:0] flush_busy;
   logic [1:0][7:0] cmd_view;
   logic [1:0][7:0] sts_view;
   logic [1:0][31:0] ptr_view;

   // One memory request bundle per channel
   dbm_mem_if mem_bus[DBM_CHANNELS] ();

   // A status read waits while that channel still flushes drive data
   always_comb begin
      io_stall = 1'b0;
      for (int c = 0; c < DBM_CHANNELS; c++) begin
         if (io_rd && io_addr[3:2] == DBM_OFS_STS[c][3:2] && io_be[DBM_OFS_STS[c][1:0]] && flush_busy[c]) begin
            io_stall = 1'b1;
         end
      end
   end

   // An access is taken once per request, never in its own answer cycle
   assign io_take = (io_rd || io_wr) && !io_ack_r && !io_stall;

   // Read word by dword slot; unmapped and device specific bytes read zero
   always_comb begin
      rd_word = 32'h00000000;
      for (int c = 0; c < DBM_CHANNELS; c++) begin
         if (io_addr[3:2] == DBM_OFS_CMD[c][3:2]) begin
            rd_word = {8'h00, sts_view[c], 8'h00, cmd_view[c]};
         end
         if (io_addr[3:2] == DBM_OFS_PTR[c][3:2]) begin
            rd_word = ptr_view[c];
         end
      end
   end

   // Register bus answer: one cycle after the take
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         io_ack_r <= 1'b0;
         io_rdata_r <= 32'h00000000;
      end else begin
         io_ack_r <= io_take;
         if (io_take && io_rd) begin
            io_rdata_r <= rd_word;
         end
      end
   end

   assign io_ack = io_ack_r;
   assign io_rdata = io_rdata_r;

   // Per-channel register file and descriptor sequencer
   for (genvar g = 0; g < DBM_CHANNELS; g++) begin : gen_chan
      localparam int CL = int'(DBM_OFS_CMD[g][1:0]);
      localparam int SL = int'(DBM_OFS_STS[g][1:0]);

      logic [7:0] cmd_r;
      logic [31:0] ptr_r;
      logic active_r;
      logic irq_r;
      logic err_r;
      logic [1:0] drv_cap_r;
      logic [1:0] mode_r;
      logic flush_r;
      logic irq_s1_r;
      logic irq_s2_r;
      logic irq_s3_r;
      logic irq_rise;
      dbm_state_t state_r;
      logic [31:0] tptr_r;
      logic [15:0] addr_hi_r;
      logic [14:0] addr_lo_r;
      logic addr_b0_r;
      logic [16:0] count_r;
      logic eot_r;
      logic [31:0] hold_r;
      logic hold_v_r;
      logic cmd_wr;
      logic sts_wr;
      logic [7:0] cmd_wbyte;
      logic [7:0] sts_wbyte;
      logic start_rise;
      logic stop;
      logic dir;
      logic retire;
      logic last;
      logic rx_take;
      logic mem_fault;

      // Write decode by dword slot and byte enable
      assign cmd_wr = io_take && io_wr && io_addr[3:2] == DBM_OFS_CMD[g][3:2] && io_be[CL];
      assign sts_wr = io_take && io_wr && io_addr[3:2] == DBM_OFS_STS[g][3:2] && io_be[SL];
      assign cmd_wbyte = io_wdata[CL * 8 +: 8];
      assign sts_wbyte = io_wdata[SL * 8 +: 8];

      // Start edge and stop detection on command writes
      assign start_rise = cmd_wr && cmd_wbyte[DBM_CMD_START_BIT] && !cmd_r[DBM_CMD_START_BIT];
      assign stop = cmd_wr && !cmd_wbyte[DBM_CMD_START_BIT] && cmd_r[DBM_CMD_START_BIT];
      assign dir = cmd_r[DBM_CMD_DIR_BIT];

      // Command register keeps only start and direction
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            cmd_r <= DBM_CMD_RESET;
         end else if (cmd_wr) begin
            cmd_r <= cmd_wbyte & DBM_CMD_RW_MASK;
         end
      end

      // Table pointer, byte-lane writable, low two bits held zero
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            ptr_r <= DBM_PTR_RESET;
         end else begin
            for (int b = 0; b < 4; b++) begin
               if (io_take && io_wr && io_addr[3:2] == DBM_OFS_PTR[g][3:2] && io_be[b]) begin
                  ptr_r[b * 8 +: 8] <= io_wdata[b * 8 +: 8] & DBM_PTR_MASK[b * 8 +: 8];
               end
            end
         end
      end

      // Drive interrupt line crosses in through two flops, then edge detect
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
            irq_s3_r <= 1'b0;
         end else begin
            irq_s1_r <= drive_interrupt_line[g];
            irq_s2_r <= irq_s1_r;
            irq_s3_r <= irq_s2_r;
         end
      end

      assign irq_rise = irq_s2_r && !irq_s3_r;

      // Interrupt and error flags: set wins over a write-one clear
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            irq_r <= 1'b0;
            err_r <= 1'b0;
         end else begin
            if (irq_rise) begin
               irq_r <= 1'b1;
            end else if (sts_wr && sts_wbyte[DBM_STS_IRQ_BIT]) begin
               irq_r <= 1'b0;
            end
            if (mem_fault) begin
               err_r <= 1'b1;
            end else if (sts_wr && sts_wbyte[DBM_STS_ERR_BIT]) begin
               err_r <= 1'b0;
            end
         end
      end

      // Software-owned drive capability bits; the drive timing mode only loads its reset value
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            drv_cap_r <= DBM_DRV_CAP_RESET;
            mode_r <= DBM_MDMA_MODE_RESET;
         end else if (sts_wr) begin
            drv_cap_r <= {sts_wbyte[DBM_STS_DRV1_BIT], sts_wbyte[DBM_STS_DRV0_BIT]};
         end
      end

      // Flush holds off status reads until the buffered drive word is written
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            flush_r <= 1'b0;
         end else if (!hold_v_r || stop || state_r != DBM_MOVE) begin
            flush_r <= 1'b0;
         end else if (irq_rise && dir) begin
            flush_r <= 1'b1;
         end
      end

      // Memory answers and transfer retirement
      assign mem_fault = mem_bus[g].err;
      assign rx_take = drv_rx_valid[g] && drv_rx_ready[g];
      assign last = count_r <= DBM_WORD_BYTES;
      always_comb begin
         retire = 1'b0;
         if (state_r == DBM_MOVE && hold_v_r) begin
            retire = dir ? (mem_bus[g].ack && !mem_fault) : drv_tx_ready[g];
         end
      end

      // Channel sequencer: fetch descriptor, move region, step or finish
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            state_r <= DBM_IDLE;
            tptr_r <= DBM_PTR_RESET;
            addr_hi_r <= 16'h0000;
            addr_lo_r <= 15'h0000;
            addr_b0_r <= 1'b0;
            count_r <= 17'h00000;
            eot_r <= 1'b0;
            hold_v_r <= 1'b0;
         end else if (stop) begin
            state_r <= DBM_IDLE;
            hold_v_r <= 1'b0;
         end else if (start_rise) begin
            state_r <= DBM_FETCH_ADDR;
            tptr_r <= ptr_r;
            hold_v_r <= 1'b0;
         end else begin
            case (state_r)
               DBM_FETCH_ADDR: begin
                  if (mem_fault) begin
                     state_r <= DBM_HALT;
                  end else if (mem_bus[g].ack) begin
                     addr_hi_r <= mem_bus[g].rdata[31:16];
                     addr_lo_r <= mem_bus[g].rdata[15:1];
                     addr_b0_r <= mem_bus[g].rdata[0];
                     state_r <= DBM_FETCH_CNT;
                  end
               end
               DBM_FETCH_CNT: begin
                  if (mem_fault) begin
                     state_r <= DBM_HALT;
                  end else if (mem_bus[g].ack) begin
                     if (mem_bus[g].rdata[15:0] == 16'h0000) begin
                        count_r <= DBM_FULL_REGION;
                     end else begin
                        count_r <= {1'b0, mem_bus[g].rdata[15:0]};
                     end
                     eot_r <= mem_bus[g].rdata[DBM_DESC_EOT_BIT];
                     state_r <= DBM_MOVE;
                  end
               end
               DBM_MOVE: begin
                  if (mem_fault) begin
                     state_r <= DBM_HALT;
                  end else if (retire) begin
                     hold_v_r <= 1'b0;
                     count_r <= count_r - DBM_WORD_BYTES;
                     addr_lo_r <= addr_lo_r + DBM_ADDR_LO_STEP;
                     if (last && eot_r) begin
                        state_r <= DBM_HALT;
                     end else if (last) begin
                        tptr_r <= {tptr_r[31:16], tptr_r[15:0] + DBM_DESC_STEP};
                        state_r <= DBM_FETCH_ADDR;
                     end
                  end else if (!dir && !hold_v_r && mem_bus[g].ack) begin
                     hold_r <= mem_bus[g].rdata;
                     hold_v_r <= 1'b1;
                  end else if (rx_take) begin
                     hold_r <= drv_rx_data[g];
                     hold_v_r <= 1'b1;
                  end
               end
               DBM_HALT: begin
                  state_r <= DBM_HALT;
               end
               default: begin
                  state_r <= DBM_IDLE;
               end
            endcase
         end
      end

      // Active flag follows start and the end of the last region
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            active_r <= 1'b0;
         end else if (stop) begin
            active_r <= 1'b0;
         end else if (start_rise) begin
            active_r <= 1'b1;
         end else if (state_r == DBM_MOVE && retire && last && eot_r) begin
            active_r <= 1'b0;
         end
      end

      // Memory requests: descriptor reads, then region reads or writes
      always_comb begin
         mem_bus[g].req = 1'b0;
         mem_bus[g].we = 1'b0;
         mem_bus[g].addr = tptr_r;
         case (state_r)
            DBM_FETCH_ADDR: begin
               mem_bus[g].req = 1'b1;
            end
            DBM_FETCH_CNT: begin
               mem_bus[g].req = 1'b1;
               mem_bus[g].addr = {tptr_r[31:16], tptr_r[15:0] + DBM_DESC_CNT_OFS};
            end
            DBM_MOVE: begin
               mem_bus[g].req = dir ? hold_v_r : !hold_v_r;
               mem_bus[g].we = dir;
               mem_bus[g].addr = {addr_hi_r, addr_lo_r, addr_b0_r};
            end
            default: begin
               mem_bus[g].req = 1'b0;
            end
         endcase
      end

      assign mem_bus[g].wdata = hold_r;

      // Drive stream: out when reading memory, in when writing it
      assign drv_tx_data[g] = hold_r;
      assign drv_tx_valid[g] = state_r == DBM_MOVE && !dir && hold_v_r;
      assign drv_rx_ready[g] = state_r == DBM_MOVE && dir && !hold_v_r && !flush_r;
      assign drive_timing_mode[g] = mode_r;

      // Register views for the read mux
      assign cmd_view[g] = cmd_r & DBM_CMD_RW_MASK;
      assign sts_view[g] = {DBM_SIMPLEX, drv_cap_r, 2'b00, irq_r, err_r, active_r};
      assign ptr_view[g] = ptr_r & DBM_PTR_MASK;
      assign flush_busy[g] = flush_r;
   end

   // Shared memory port
   dbm_arb u_arb (
      .clock(clock),
      .rst_n(rst_n),
      .ch0(mem_bus[0]),
      .ch1(mem_bus[1]),
      .mem_req(mem_req),
      .mem_we(mem_we),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata),
      .mem_ack(mem_ack),
      .mem_err(mem_err)
   );

endmodule : dbm_top

`default_nettype wire

/* testbench/dbm_top_props.sv */
// Concurrent checks on the register window, memory port and drive streams
`timescale 1ns/1ps
`default_nettype none

module dbm_top_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [31:0] io_rdata,
   input wire logic io_ack,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [1:0][31:0] drv_tx_data,
   input wire logic [1:0] drv_tx_valid,
   input wire logic [1:0] drv_tx_ready,
   input wire logic [1:0] drv_rx_ready,
   input wire logic [1:0][1:0] drive_timing_mode
);
   // Every check samples on the rising edge outside reset
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_ack_pulse: assert property (io_ack |=> !io_ack)
      else $error("io_ack held past one cycle");
   a_plain_answer: assert property ((io_wr || (io_rd && io_addr[2])) && !io_ack |=> io_ack)
      else $error("access not answered next cycle");
   a_cmd_reserved: assert property (io_ack && $past(io_rd) && !$past(io_addr[2]) |->
      (io_rdata & 32'hFF98FFF6) == 32'h00000000)
      else $error("reserved command or status bits read nonzero");
   a_ptr_aligned: assert property (io_ack && $past(io_rd) && $past(io_addr[2]) |-> io_rdata[1:0] == 2'h0)
      else $error("pointer low bits read nonzero");
   a_mode_zero: assert property (drive_timing_mode == 4'h0)
      else $error("drive timing left mode zero");
   a_reset_quiet: assert property ($rose(rst_n) |-> !io_ack && !mem_req && drv_tx_valid == 2'h0)
      else $error("outputs active right after reset");
   a_dir_exclusive: assert property ((drv_tx_valid & drv_rx_ready) == 2'h0)
      else $error("both stream directions open on a channel");
   a_tx_hold: assert property (drv_tx_valid[0] && !drv_tx_ready[0] && !io_wr |=>
      drv_tx_valid[0] && $stable(drv_tx_data[0]))
      else $error("drive word dropped or changed while waiting");
   a_mem_hold: assert property (mem_req && !mem_ack && !io_wr |=> mem_req && $stable(mem_addr))
      else $error("memory request moved before its answer");
endmodule : dbm_top_props

bind dbm_top dbm_top_props u_props (
   .clock(clock),
   .rst_n(rst_n),
   .io_addr(io_addr),
   .io_rd(io_rd),
   .io_wr(io_wr),
   .io_rdata(io_rdata),
   .io_ack(io_ack),
   .mem_req(mem_req),
   .mem_addr(mem_addr),
   .mem_ack(mem_ack),
   .drv_tx_data(drv_tx_data),
   .drv_tx_valid(drv_tx_valid),
   .drv_tx_ready(drv_tx_ready),
   .drv_rx_ready(drv_rx_ready),
   .drive_timing_mode(drive_timing_mode)
);

`default_nettype wire

/* testbench/dbm_mem_model.sv */
// System memory model for the engine's memory port
`timescale 1ns/1ps
`default_nettype none

module dbm_mem_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   output logic mem_err,
   input wire logic [1:0] lat,
   input wire logic [31:0] err_addr
);
   logic [31:0] mem [512];
   logic [1:0] wait_r;
   logic [31:0] last_r;

   // Answer after lat wait cycles; dword aligned tables and regions only
   assign mem_ack = mem_req && wait_r >= lat;
   assign mem_err = mem_ack && mem_addr == err_addr;
   // Outside an answer the bus shows the last word inverted
   assign mem_rdata = mem_ack ? mem[mem_addr[10:2]] : ~last_r;

   // Wait counter and last word seen
   always_ff @(posedge clock) begin
      if (!rst_n || mem_ack || !mem_req) wait_r <= 2'h0;
      else wait_r <= wait_r + 2'h1;
      if (!rst_n) last_r <= 32'h00000000;
      else if (mem_ack) last_r <= mem_rdata;
   end

   // Writes land in the array
   always @(posedge clock) begin
      if (mem_ack && mem_we) mem[mem_addr[10:2]] <= mem_wdata;
   end
endmodule : dbm_mem_model

`default_nettype wire

/* testbench/dbm_top_tb.sv */
// Self-checking bench for the disk bus-master engine
`timescale 1ns/1ps
`default_nettype none

module dbm_top_tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] io_addr = 4'h0;
   logic [3:0] io_be = 4'h0;
   logic io_rd = 1'b0;
   logic io_wr = 1'b0;
   logic [31:0] io_wdata = 32'h00000000;
   logic [31:0] io_rdata, mem_addr, mem_wdata, mem_rdata, rd_data;
   logic [31:0] err_addr = 32'hFFFFFFFF;
   logic io_ack, mem_req, mem_we, mem_ack, mem_err;
   logic [1:0][31:0] drv_tx_data;
   logic [1:0][31:0] drv_rx_data = 64'h0;
   logic [1:0] drv_tx_valid, drv_rx_ready;
   logic [1:0] drv_tx_ready = 2'h0;
   logic [1:0] drv_rx_valid = 2'h0;
   logic [1:0] drive_interrupt_line = 2'h0;
   logic [1:0] lat = 2'h0;
   logic [1:0][1:0] drive_timing_mode;
   logic [31:0] words [8];
   int fail_count = 0;
   int n_checks = 0;

   // Free-running 100 MHz clock
   always #5 clock = ~clock;

   dbm_top u_dut (
      .clock(clock), .rst_n(rst_n), .io_addr(io_addr), .io_be(io_be), .io_rd(io_rd),
      .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
      .drv_tx_data(drv_tx_data), .drv_tx_valid(drv_tx_valid), .drv_tx_ready(drv_tx_ready),
      .drv_rx_data(drv_rx_data), .drv_rx_valid(drv_rx_valid), .drv_rx_ready(drv_rx_ready),
      .drive_interrupt_line(drive_interrupt_line), .drive_timing_mode(drive_timing_mode));

   dbm_mem_model u_mem (
      .clock(clock), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
      .lat(lat), .err_addr(err_addr));

   // Verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bail(input logic ok);
      if (!ok) begin
         fail_count++;
         end_of_test();
      end
   endtask : bail

   // One register access, held until acknowledged
   task automatic io(input logic wr, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
      int i;
      @(negedge clock);
      io_wr = wr;
      io_rd = !wr;
      io_addr = a;
      io_be = be;
      io_wdata = d;
      for (i = 0; i < 300 && io_ack !== 1'b1; i++) @(negedge clock);
      bail(io_ack === 1'b1);
      rd_data = io_rdata;
      @(negedge clock);
      io_wr = 1'b0;
      io_rd = 1'b0;
   endtask : io

   // Poll a status dword until it matches
   task automatic wait_sts(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      int i;
      for (i = 0; i < 200; i++) begin
         io(1'b0, a, 4'hF, 32'h00000000);
         if ((rd_data & m) === e) break;
      end
      chk(rd_data & m, e);
   endtask : wait_sts

   // Collect n primary drive words
   task automatic grab(input int n);
      int i;
      int k = 0;
      for (i = 0; i < 3000 && k < n; i++) begin
         if (drv_tx_valid[0] && drv_tx_ready[0]) begin
            words[k] = drv_tx_data[0];
            k++;
         end
         @(negedge clock);
      end
      bail(k >= n);
   endtask : grab

   // One secondary word from the drive
   task automatic send(input logic [31:0] d);
      int i;
      @(negedge clock);
      drv_rx_valid[1] = 1'b1;
      drv_rx_data[1] = d;
      for (i = 0; i < 100 && drv_rx_ready[1] !== 1'b1; i++) @(negedge clock);
      bail(drv_rx_ready[1] === 1'b1);
      @(negedge clock);
      drv_rx_valid[1] = 1'b0;
      drv_rx_data[1] = ~d;
   endtask : send

   task automatic t_reset();
      int a;
      for (a = 0; a < 16; a += 4) begin
         io(1'b0, a[3:0], 4'hF, 32'h00000000);
         chk(rd_data, 32'h00000000);
      end
      chk({28'h0, drive_timing_mode}, 32'h00000000);
   endtask : t_reset

   task automatic t_regs();
      io(1'b1, 4'h4, 4'hF, 32'hFFFFFFFF);
      io(1'b1, 4'hC, 4'h3, 32'h12345678);
      io(1'b1, 4'h0, 4'h7, 32'h0060A5FE);
      io(1'b0, 4'h4, 4'hF, 32'h00000000);
      chk(rd_data, 32'hFFFFFFFC);
      io(1'b0, 4'hC, 4'hF, 32'h00000000);
      chk(rd_data, 32'h00005678);
      io(1'b0, 4'h0, 4'hF, 32'h00000000);
      chk(rd_data, 32'h00600008);
      chk({31'h0, mem_req}, 32'h00000000);
      io(1'b1, 4'h0, 4'hF, 32'h00000000);
   endtask : t_regs

   task automatic t_dir0();
      u_mem.mem[9'h040] = 32'h00000200;
      u_mem.mem[9'h041] = 32'h00000008;
      u_mem.mem[9'h042] = 32'h00000300;
      u_mem.mem[9'h043] = 32'h80000004;
      u_mem.mem[9'h080] = 32'hD0000001;
      u_mem.mem[9'h081] = 32'hD0000002;
      u_mem.mem[9'h0C0] = 32'hD0000003;
      io(1'b1, 4'h4, 4'hF, 32'h00000100);
      io(1'b1, 4'h0, 4'h1, 32'h00000001);
      drv_tx_ready[0] = 1'b1;
      grab(3);
      chk(words[0], 32'hD0000001);
      chk(words[1], 32'hD0000002);
      chk(words[2], 32'hD0000003);
      wait_sts(4'h0, 32'h00010000, 32'h00000000);
      io(1'b1, 4'h0, 4'h1, 32'h00000001);
      repeat (3) @(negedge clock);
      chk({31'h0, mem_req}, 32'h00000000);
      io(1'b1, 4'h0, 4'h1, 32'h00000000);
      drv_tx_ready[0] = 1'b0;
   endtask : t_dir0

   task automatic t_dir1();
      lat = 2'h3;
      u_mem.mem[9'h060] = 32'h00000380;
      u_mem.mem[9'h061] = 32'h8000000C;
      io(1'b1, 4'hC, 4'hF, 32'h00000180);
      io(1'b1, 4'h8, 4'h1, 32'h00000008);
      io(1'b1, 4'h8, 4'h1, 32'h00000009);
      send(32'hE1E1E1E1);
      send(32'hE2E2E2E2);
      drive_interrupt_line[1] = 1'b1;
      wait_sts(4'h8, 32'h00040000, 32'h00040000);
      chk(u_mem.mem[9'h0E1], 32'hE2E2E2E2);
      chk(u_mem.mem[9'h0E0], 32'hE1E1E1E1);
      chk(rd_data, 32'h00050009);
      drive_interrupt_line[1] = 1'b0;
      io(1'b1, 4'h8, 4'h4, 32'h00040000);
      io(1'b0, 4'h8, 4'hF, 32'h00000000);
      chk(rd_data, 32'h00010009);
      io(1'b1, 4'h8, 4'h1, 32'h00000008);
      io(1'b0, 4'h8, 4'hF, 32'h00000000);
      chk(rd_data, 32'h00000008);
      lat = 2'h0;
   endtask : t_dir1

   task automatic t_abort();
      int k;
      u_mem.mem[9'h050] = 32'h00000400;
      u_mem.mem[9'h051] = 32'h00000000;
      for (k = 0; k < 8; k++) u_mem.mem[9'h100 + k] = 32'hC0DE0000 + k;
      io(1'b1, 4'h4, 4'hF, 32'h00000140);
      io(1'b1, 4'h0, 4'h1, 32'h00000001);
      drv_tx_ready[0] = 1'b1;
      grab(8);
      for (k = 0; k < 8; k++) chk(words[k], 32'hC0DE0000 + k);
      drv_tx_ready[0] = 1'b0;
      io(1'b1, 4'h0, 4'h1, 32'h00000000);
      io(1'b0, 4'h0, 4'hF, 32'h00000000);
      chk(rd_data, 32'h00000000);
      chk({31'h0, mem_req}, 32'h00000000);
      lat = 2'h3;
      io(1'b1, 4'h0, 4'h1, 32'h00000001);
      chk(mem_addr, 32'h00000140);
      io(1'b1, 4'h0, 4'h1, 32'h00000000);
      lat = 2'h0;
   endtask : t_abort

   task automatic t_err();
      err_addr = 32'h00000144;
      io(1'b1, 4'h0, 4'h1, 32'h00000001);
      wait_sts(4'h0, 32'h00030000, 32'h00030000);
      io(1'b1, 4'h0, 4'h1, 32'h00000000);
      io(1'b1, 4'h0, 4'h4, 32'h00020000);
      io(1'b0, 4'h0, 4'hF, 32'h00000000);
      chk(rd_data, 32'h00000000);
      err_addr = 32'hFFFFFFFF;
   endtask : t_err

   // Main sequence
   initial begin
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_dir0();
      t_dir1();
      t_abort();
      t_err();
      end_of_test();
   end
endmodule : dbm_top_tb

`default_nettype wire
